// ===== dctom_checker.sv
`timescale 1ns/1ps
// ==========
// Port checker of the torque off supervisor
module dctom_checker
  import dctom_pkg::*;
#(
  parameter int TICK_CYCLES  = 20,
  parameter int WINDOW_TICKS = 3,
  parameter int PULSE_CYCLES = 4
) (
  input wire logic         core_clk,
  input wire logic         reset_n,
  input wire logic         supply_a,
  input wire logic         supply_b,
  input wire logic         pwm_request,
  input wire logic         error_ack,
  input wire logic         control_enable_q,
  input wire logic         pwm_enable_q,
  input wire logic         brake_drive_q,
  input wire logic         safe_state_q,
  input wire logic         error_q,
  input wire logic [2:0]   error_flags_q,
  input wire dctom_state_t state_q
);
  // Low run lengths and cycles since the last state move
  logic [15:0] la_q, lb_q, gap_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      la_q  <= 16'h0;
      lb_q  <= 16'h0;
      gap_q <= 16'h0;
    end else begin
      la_q  <= supply_a ? 16'h0 : la_q + 16'h1;
      lb_q  <= supply_b ? 16'h0 : lb_q + 16'h1;
      gap_q <= $changed(state_q) ? 16'h0 : gap_q + 16'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_cut;
    la_q == PULSE_CYCLES || lb_q == PULSE_CYCLES;
  endsequence
  sequence s_pwm_lost;
    $fell(pwm_enable_q) && $past(pwm_request);
  endsequence
  sequence s_fault_in;
    $changed(state_q) && state_q == DCTOM_FAULT;
  endsequence
  AST_SHORT_LOW: assert property (s_pwm_lost |->
    la_q >= PULSE_CYCLES || lb_q >= PULSE_CYCLES) else $error("pwm lost on short low");
  AST_CUTOFF: assert property (s_cut |-> ##[0:2] !pwm_enable_q && !control_enable_q)
    else $error("pwm not cut");
  AST_BRAKE: assert property (s_cut |-> ##[0:2] !brake_drive_q)
    else $error("brake still driven");
  AST_PWM_ERR: assert property (s_pwm_lost |-> error_flags_q[1])
    else $error("no error for request under pwm");
  AST_SAFE_LAG: assert property (1'b1 |=> safe_state_q == ($past(state_q) == DCTOM_SAFE))
    else $error("safe flag wrong");
  AST_TICK_PACE: assert property ($changed(state_q) |-> gap_q >= TICK_CYCLES - 1)
    else $error("state moved between ticks");
  AST_WINDOW: assert property (s_fault_in |->
    $past(state_q) == DCTOM_ONE_OFF && error_flags_q[0] &&
    gap_q >= (WINDOW_TICKS - 1) * TICK_CYCLES - 1) else $error("bad fault");
  // Supplies high one cycle earlier, so the filters already report both present
  AST_ACK: assert property (
    error_ack && $past(supply_a) && $past(supply_b) && state_q != DCTOM_ONE_OFF
    |=> error_flags_q == 3'h0) else $error("ack left flags");
  AST_ERR_OR: assert property (error_q == |error_flags_q)
    else $error("error summary wrong");
endmodule

bind dctom_monitor dctom_checker #(
  .TICK_CYCLES(TICK_CYCLES), .WINDOW_TICKS(WINDOW_TICKS), .PULSE_CYCLES(PULSE_CYCLES)
) u_chk (
  .core_clk, .reset_n, .supply_a, .supply_b, .pwm_request, .error_ack, .control_enable_q,
  .pwm_enable_q, .brake_drive_q, .safe_state_q, .error_q, .error_flags_q, .state_q
);

// ===== dctom_defs.svh
// What this block does
// - Torque off when both inactive within window
// - Error when second channel misses window
// - Discrepancy window defaults to 100 ms
// - Supervisory machine evaluated every 10 ms
// - Safe state reported after discrepancy evaluation
// - Short test pulses never count as request
// - State derived from driver supply, not pins
// - Cutoff faults captured, error message raised
// - One acknowledge clears all safety errors
// - Request disables control loop and PWM
// - Request releases configured holding brake drive
// - Status and errors shown on outputs
// - Request while PWM runs raises error
// - Channels compared each tick, long mismatch errors
// - Cutoff path itself has no diagnostics
// - Only the two request inputs request torque-off
`ifndef DCTOM_DEFS_SVH
`define DCTOM_DEFS_SVH
`define DCTOM_CLK_HZ        20000000
`define DCTOM_TICK_MS       10
`define DCTOM_TICK_CYCLES   ((`DCTOM_CLK_HZ / 1000) * `DCTOM_TICK_MS)
`define DCTOM_WINDOW_MS     100
`define DCTOM_WINDOW_TICKS  (`DCTOM_WINDOW_MS / `DCTOM_TICK_MS)
`define DCTOM_PULSE_US      1000
`define DCTOM_PULSE_CYCLES  ((`DCTOM_CLK_HZ / 1000000) * `DCTOM_PULSE_US)
`define DCTOM_MISMATCH_TICKS 50
`define DCTOM_ERR_DISCREP   0
`define DCTOM_ERR_PWM_ON    1
`define DCTOM_ERR_MISMATCH  2
`define DCTOM_ERR_WIDTH     3
`endif

// ===== dctom_filter.sv
`timescale 1ns/1ps
`include "dctom_defs.svh"
// =====================================================================
// Test pulse filter: a low level counts only once it outlasts the pulse
module dctom_filter #(
  parameter int PULSE_CYCLES = `DCTOM_PULSE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic raw_in,
  output logic      clean_q
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        clean_d;
  logic        settled;

  // Rising edges pass at once: release must not be delayed by a pulse
  assign settled = (cnt_q >= PULSE_CYCLES[31:0]);
  assign cnt_d   = raw_in ? 32'h0 : (settled ? cnt_q : cnt_q + 32'h1);
  assign clean_d = raw_in ? 1'b1 : (settled ? 1'b0 : clean_q);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q   <= 32'h0;
      clean_q <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      clean_q <= clean_d;
    end
  end
endmodule

// ===== dctom_monitor.sv
`timescale 1ns/1ps
`include "dctom_defs.svh"
// =====================================================================
// Two channel torque off supervisor
module dctom_monitor #(
  parameter int TICK_CYCLES     = `DCTOM_TICK_CYCLES,
  parameter int WINDOW_TICKS    = `DCTOM_WINDOW_TICKS,
  parameter int MISMATCH_TICKS  = `DCTOM_MISMATCH_TICKS,
  parameter int PULSE_CYCLES    = `DCTOM_PULSE_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire logic                      supply_a,
  input  wire logic                      supply_b,
  input  wire logic                      pwm_request,
  input  wire logic                      brake_release_request,
  input  wire logic                      brake_configured,
  input  wire logic                      error_ack,
  output logic                           control_enable_q,
  output logic                           pwm_enable_q,
  output logic                           brake_drive_q,
  output logic                           safe_state_q,
  output logic                           error_q,
  output logic [`DCTOM_ERR_WIDTH-1:0]    error_flags_q,
  output dctom_pkg::dctom_state_t        state_q
);
  import dctom_pkg::*;

  // ===================================================================
  // Input conditioning
  // Inputs are the driver supply levels the cutoff path produces
  logic a_ok;
  logic b_ok;

  dctom_filter #(.PULSE_CYCLES(PULSE_CYCLES)) u_filt_a (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (supply_a),
    .clean_q  (a_ok)
  );

  dctom_filter #(.PULSE_CYCLES(PULSE_CYCLES)) u_filt_b (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (supply_b),
    .clean_q  (b_ok)
  );

  // ===================================================================
  // Evaluation tick
  logic [31:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ===================================================================
  // Supervisory state machine, only stepped on the tick
  // Torque-off can only come from the two supplies; no other port requests it
  logic        both_off;
  logic        one_off;
  logic        both_on;
  logic [15:0] win_q;
  logic [15:0] win_d;
  logic [15:0] mis_q;
  logic [15:0] mis_d;
  logic        win_expired;
  logic        mis_expired;
  dctom_state_t state_d;

  assign both_off    = !a_ok && !b_ok;
  assign both_on     = a_ok && b_ok;
  assign one_off     = a_ok ^ b_ok;
  assign win_expired = (win_q >= 16'(WINDOW_TICKS));
  assign mis_expired = (mis_q >= 16'(MISMATCH_TICKS));

  always_comb begin
    state_d = state_q;
    win_d   = win_q;
    if (tick) begin
      unique case (state_q)
        DCTOM_RUN: begin
          win_d = 16'h0;
          if (both_off) begin
            state_d = DCTOM_SAFE;
          end else if (one_off) begin
            state_d = DCTOM_ONE_OFF;
            win_d   = 16'h1;
          end
        end
        DCTOM_ONE_OFF: begin
          if (both_off) begin
            state_d = DCTOM_SAFE;
          end else if (both_on) begin
            state_d = DCTOM_RUN;
          end else if (win_expired) begin
            state_d = DCTOM_FAULT;
          end else begin
            win_d = win_q + 16'h1;
          end
        end
        DCTOM_SAFE: begin
          if (both_on) begin
            state_d = DCTOM_RUN;
          end else if (one_off) begin
            state_d = DCTOM_ONE_OFF;
            win_d   = 16'h1;
          end
        end
        DCTOM_FAULT: begin
          // Leaves only once acknowledged and the channels agree again
          if (!error_q && both_on) begin
            state_d = DCTOM_RUN;
          end else if (!error_q && both_off) begin
            state_d = DCTOM_SAFE;
          end
        end
        default: state_d = DCTOM_FAULT;
      endcase
    end
  end

  // Long unequal supply levels, counted on ticks
  assign mis_d = !tick ? mis_q
               : (one_off ? (mis_expired ? mis_q : mis_q + 16'h1) : 16'h0);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DCTOM_RUN;
      win_q   <= 16'h0;
      mis_q   <= 16'h0;
    end else begin
      state_q <= state_d;
      win_q   <= win_d;
      mis_q   <= mis_d;
    end
  end

  // ===================================================================
  // Errors: set wins over acknowledge; one acknowledge clears them all
  logic                        req_seen;
  logic [`DCTOM_ERR_WIDTH-1:0] err_set;
  logic [`DCTOM_ERR_WIDTH-1:0] err_d;
  logic                        prev_any_off_q;

  assign req_seen = !(a_ok && b_ok) && prev_any_off_q == 1'b0;
  assign err_set[`DCTOM_ERR_DISCREP]  = tick && state_q == DCTOM_ONE_OFF && one_off
                                        && win_expired;
  assign err_set[`DCTOM_ERR_PWM_ON]   = req_seen && pwm_enable_q;
  assign err_set[`DCTOM_ERR_MISMATCH] = tick && one_off && mis_expired;
  assign err_d = (error_ack ? '0 : error_flags_q) | err_set;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_flags_q  <= '0;
      prev_any_off_q <= 1'b0;
      error_q        <= 1'b0;
    end else begin
      error_flags_q  <= err_d;
      prev_any_off_q <= !(a_ok && b_ok);
      error_q        <= |err_d;
    end
  end

  // ===================================================================
  // Drive outputs: shut down immediately on any dropped supply, not on the tick
  // The cutoff itself is analog; these only stop the firmware side driving
  logic off_now;
  assign off_now = !(a_ok && b_ok);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_enable_q <= 1'b0;
      pwm_enable_q     <= 1'b0;
      brake_drive_q    <= 1'b0;
      safe_state_q     <= 1'b0;
    end else begin
      control_enable_q <= !off_now && pwm_request;
      pwm_enable_q     <= !off_now && pwm_request;
      brake_drive_q    <= brake_configured && !off_now && brake_release_request;
      safe_state_q     <= (state_q == DCTOM_SAFE);
    end
  end
endmodule

// ===== dctom_partner.sv
`timescale 1ns/1ps
// ==========
// Request source: a relay driving both driver supplies
module dctom_partner (
  input  wire logic req_a,
  input  wire logic req_b,
  input  wire logic pulse,
  output wire logic supply_a,
  output wire logic supply_b
);
  // Cross faults are the relay's to detect, so none are modelled
  assign supply_a = !(req_a || pulse);
  assign supply_b = !(req_b || pulse);
endmodule

// ===== dctom_pkg.sv
package dctom_pkg;
  typedef enum logic [2:0] {
    DCTOM_RUN,
    DCTOM_ONE_OFF,
    DCTOM_SAFE,
    DCTOM_FAULT
  } dctom_state_t;
endpackage

// ===== dual_channel_torque_off_monitor_test.sv
`timescale 1ns/1ps
// ==========
// Bench: drives the relay model, scoreboards state moves
module dual_channel_torque_off_monitor_test;
  import dctom_pkg::*;
  localparam int TICK = 20;
  localparam int MIS  = 5;
  logic core_clk, reset_n, req_a, req_b, pulse, supply_a, supply_b, error_ack;
  logic pwm_request, brake_release_request, brake_configured, error_q;
  logic control_enable_q, pwm_enable_q, brake_drive_q, safe_state_q;
  logic [2:0]   error_flags_q;
  dctom_state_t state_q, last_s;
  dctom_state_t exp_q[$];
  int err_count = 0, n_tests = 0, cyc = 0, seed = 23;
  dctom_partner far (.req_a, .req_b, .pulse, .supply_a, .supply_b);
  dctom_monitor #(.TICK_CYCLES(TICK), .WINDOW_TICKS(3), .MISMATCH_TICKS(MIS),
                  .PULSE_CYCLES(4)) dut (
    .core_clk, .reset_n, .supply_a, .supply_b, .pwm_request, .brake_release_request,
    .brake_configured, .error_ack, .control_enable_q, .pwm_enable_q, .brake_drive_q,
    .safe_state_q, .error_q, .error_flags_q, .state_q);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic settle;
    for (int n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    if (exp_q.size() != 0) chk(8'h0, 8'h1);
  endtask
  task automatic clear_req;
    req_a <= 1'b0;
    req_b <= 1'b0;
    exp_q.push_back(DCTOM_RUN);
    repeat (2) @(posedge core_clk);
    error_ack <= 1'b1;
    @(posedge core_clk);
    error_ack <= 1'b0;
    settle();
    chk(error_flags_q, 8'h0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  // ==========
  // Every settled state move, except one into DCTOM_ONE_OFF, must match the oldest note
  initial forever begin
    @(negedge core_clk);
    if (reset_n && state_q !== last_s && state_q !== DCTOM_ONE_OFF) begin
      if (exp_q.size() == 0) chk(8'(state_q), 8'hFF);
      else chk(8'(state_q), 8'(exp_q.pop_front()));
    end
    last_s = state_q;
  end
  initial begin
    reset_n = 1'b0;
    {req_a, req_b, pulse, error_ack} = 4'h0;
    {pwm_request, brake_release_request, brake_configured} = 3'h7;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) begin
      repeat (9) @(posedge core_clk);
      pulse <= 1'b1;
      repeat (1 + {$random(seed)} % 3) @(posedge core_clk);
      pulse <= 1'b0;
    end
    chk(pwm_enable_q, 8'h1);
    chk(error_q, 8'h0);
    chk(brake_drive_q & control_enable_q, 8'h1);
    // Without a configured brake the brake drive stays off even when healthy
    brake_configured <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(brake_drive_q, 8'h0);
    brake_configured <= 1'b1;
    exp_q.push_back(DCTOM_SAFE);
    req_a <= 1'b1;
    req_b <= 1'b1;
    settle();
    chk(pwm_enable_q | control_enable_q, 8'h0);
    chk(brake_drive_q, 8'h0);
    chk(error_flags_q, 8'h2);
    chk(safe_state_q & error_q, 8'h1);
    clear_req();
    // Staggered request with the power stage already off: no error may follow
    exp_q.push_back(DCTOM_SAFE);
    pwm_request <= 1'b0;
    req_b <= 1'b1;
    repeat ({$random(seed)} % TICK) @(posedge core_clk);
    req_a <= 1'b1;
    settle();
    chk(safe_state_q, 8'h1);
    chk(error_flags_q, 8'h0);
    pwm_request <= 1'b1;
    clear_req();
    exp_q.push_back(DCTOM_FAULT);
    req_a <= 1'b1;
    settle();
    chk(error_flags_q[0], 8'h1);
    repeat (MIS * TICK) @(posedge core_clk);
    chk(error_flags_q[2], 8'h1);
    clear_req();
    stop_test();
  end
endmodule
